//--- logic/osd_font_regs.svh
// register offsets, field positions, reset values and font geometry for the glyph renderer
`ifndef OSD_FONT_REGS_SVH
`define OSD_FONT_REGS_SVH
`define DISPLAY_CONFIG_OFF  16'h87ff
`define FONT_BASE_OFF       16'hc000
`define FONT_BYTES          16'h1600
`define CFG_CC_BIT          7
`define CFG_LATE_BIT        6
`define CFG_ALIGN_BIT       5
`define CFG_EARLY_BIT       4
`define CFG_WRITE_MASK      8'hf0
`define CFG_RESET           8'h00
`define GLYPH_WIDTH         12
`define GLYPH_LINES         16
`define FIRST_VISIBLE_LINE  4'h1
`define LAST_VISIBLE_LINE   4'hd
`define FRINGE_TOP_LINE     4'h0
`define FRINGE_BOTTOM_LINE  4'he
`define PROP_LOW_BIT        6
`define CHAR_COUNT          176
`define NORMAL_COUNT        128
`define SPECIAL_COUNT       32
`define PROP_COUNT          16
`endif

//--- logic/osd_font_pkg.sv
// types shared by the glyph renderer
package osd_font_pkg;
  typedef enum logic [1:0] {
    GLYPH_NORMAL  = 2'b00,
    GLYPH_PROP    = 2'b01,
    GLYPH_SPECIAL = 2'b10
  } glyph_kind_t;
endpackage

//--- logic/osd_font_rom_blank_timing.sv
// character font store, glyph pixel shifter and fast-blank timing with a wishbone register port
//
// How it works
// - config bit 7 picks plain display when 0, closed caption when 1; plain after reset
// - in closed caption mode underline is suppressed on serial attribute cells
// - bits 6..4 set fast blank: 000 off, 001 early, 010 aligned, 100 late
// - other codes OR together the windows of their set bits
// - glyphs are twelve pixels wide and thirteen visible lines tall
// - each character is sixteen consecutive twelve-bit font words
// - font words shift out msb first, bit 11 leftmost
// - lines 0 and 14 serve only for fringing across rows
// - lines 1..13 give the visible glyph; line 15 never shows
// - proportional characters show only bits 11 down to 6
// - proportional words carry next line's upper six bits in their low six
// - proportional characters are shown only from the first table column
// - special characters use an even location for plane 0, odd for plane 1
// - special pixel colour is the two plane bits combined
// - no shadowing on special characters
// - special planes ignore fringing line contents
// - font addresses are twelve-bit word addresses; cpu uses two byte accesses
// - 128 normal, 32 special, 16 proportional: 176 characters
`include "osd_font_regs.svh"

module osd_font_rom_blank_timing #(
  parameter int CHARS = `CHAR_COUNT
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave, byte wide
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [0:0]  sel_i,
  input  wire logic [7:0]  dat_i,
  output logic      [7:0]  dat_o,
  output logic             ack_o,
  // character stream, one pixel per clock
  input  wire logic        pix_valid_i,
  input  wire logic [7:0]  char_code_i,
  input  wire logic [3:0]  char_line_i,
  input  wire logic [3:0]  pix_col_i,
  input  wire logic        first_column_i,
  input  wire logic        serial_attr_i,
  input  wire logic        underline_i,
  input  wire logic        shadow_i,
  // video outputs
  output logic      [1:0]  pixel_colour_o,
  output logic             pixel_on_o,
  output logic             underline_o,
  output logic             shadow_o,
  output logic             fringe_o,
  output logic             fast_blank_out,
  output logic             closed_caption_select
);

  localparam int WORDS = CHARS * `GLYPH_LINES;

  logic [7:0]  display_config;
  logic [11:0] font_mem [WORDS];
  logic        ack;
  logic [7:0]  rd_data;

  // bus decode: font bytes are low/high halves of each twelve-bit word
  wire         req       = cyc_i & stb_i & ~ack;
  wire         hit_cfg   = adr_i == `DISPLAY_CONFIG_OFF;
  wire [15:0]  font_off  = adr_i - `FONT_BASE_OFF;
  wire         hit_font  = (adr_i >= `FONT_BASE_OFF) && (font_off < `FONT_BYTES);
  wire [11:0]  bus_word  = font_off[12:1];
  wire         bus_high  = font_off[0];
  wire         bus_ok    = hit_font && (int'(bus_word) < WORDS);
  wire [11:0]  bus_fword = bus_ok ? font_mem[bus_word] : 12'h000;
  wire [7:0]   next_rd   = hit_cfg ? display_config :
                           bus_ok  ? (bus_high ? {4'h0, bus_fword[11:8]} : bus_fword[7:0]) : 8'h00;
  wire         wr_strobe = cyc_i & stb_i & we_i & sel_i[0] & ack; // lands at the ack edge only

  // one wait state: ack the cycle after the request is seen, drop it next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack     <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      ack     <= req;
      rd_data <= next_rd;
    end
  end
  assign ack_o = ack;
  assign dat_o = rd_data;

  // bus answers: every taken request is acked next cycle with defined data
  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      req |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acked next cycle");

  property p_unmapped_read;
    @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && !hit_cfg && !hit_font) |=> dat_o == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_font_high_read;
    @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_font && adr_i[0]) |=> dat_o[7:4] == 4'h0;
  endproperty
  a_font_high_read: assert property (p_font_high_read) else $error("font high byte upper nibble set");

  // only the mode and blank code bits are stored; low nibble reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      display_config <= `CFG_RESET;
    end else if (wr_strobe && hit_cfg) begin
      display_config <= dat_i & `CFG_WRITE_MASK;
    end
  end

  // font store: a write fills one half of a word, keeping the other half
  always_ff @(posedge clk_i) begin
    if (wr_strobe && bus_ok) begin
      if (bus_high) begin
        font_mem[bus_word][11:8] <= dat_i[3:0];
      end else begin
        font_mem[bus_word][7:0] <= dat_i;
      end
    end
  end

  // glyph classification: codes 0..127 normal, 128..159 special, 160..175 proportional
  osd_font_pkg::glyph_kind_t kind;
  assign kind = (char_code_i < 8'(`NORMAL_COUNT)) ? osd_font_pkg::GLYPH_NORMAL :
                (char_code_i < 8'(`NORMAL_COUNT + `SPECIAL_COUNT)) ? osd_font_pkg::GLYPH_SPECIAL :
                osd_font_pkg::GLYPH_PROP;

  // display address: sixteen words per character, special pairs from even code
  wire [7:0]  even_code  = {char_code_i[7:1], 1'b0};
  wire [11:0] addr_p0    = 12'({even_code, char_line_i});
  wire [11:0] addr_p1    = 12'({even_code | 8'h01, char_line_i});
  wire [11:0] addr_n     = 12'({char_code_i, char_line_i});
  wire        code_ok    = char_code_i < 8'(CHARS);
  wire [11:0] word_n     = code_ok ? font_mem[addr_n] : 12'h000;
  wire [11:0] word_p0    = code_ok ? font_mem[addr_p0] : 12'h000;
  wire [11:0] word_p1    = code_ok ? font_mem[addr_p1] : 12'h000;

  // line classes
  wire visible    = char_line_i >= `FIRST_VISIBLE_LINE &&
                    char_line_i <= `LAST_VISIBLE_LINE;
  wire fringe_ln  = char_line_i == `FRINGE_TOP_LINE ||
                    char_line_i == `FRINGE_BOTTOM_LINE;
  wire col_ok     = pix_col_i < 4'(`GLYPH_WIDTH);
  wire [3:0] bit_ix = 4'(`GLYPH_WIDTH - 1) - pix_col_i;

  // per-pixel selection
  wire n_bit      = col_ok && word_n[bit_ix];
  wire p0_bit     = col_ok && word_p0[bit_ix];
  wire p1_bit     = col_ok && word_p1[bit_ix];
  // proportional: low six bits duplicate the next line, never shown
  wire prop_col   = pix_col_i < 4'(`GLYPH_WIDTH - `PROP_LOW_BIT);
  wire prop_show  = first_column_i;

  logic [1:0] next_colour;
  logic       next_on;
  logic       next_fringe;
  always_comb begin
    next_colour = 2'b00;
    next_on     = 1'b0;
    next_fringe = 1'b0;
    case (kind)
      osd_font_pkg::GLYPH_SPECIAL: begin
        // planes combine into a colour index; fringing lines ignored
        if (visible) begin
          next_colour = {p1_bit, p0_bit};
          next_on     = p1_bit | p0_bit;
        end
      end
      osd_font_pkg::GLYPH_PROP: begin
        if (visible && prop_col && prop_show) begin
          next_on     = n_bit;
          next_colour = {1'b0, n_bit};
        end
      end
      osd_font_pkg::GLYPH_NORMAL: begin
        if (visible) begin
          next_on     = n_bit;
          next_colour = {1'b0, n_bit};
        end
        next_fringe = fringe_ln & n_bit;
      end
      default: begin
        next_on = 1'b0;
      end
    endcase
  end

  wire cc_mode    = display_config[`CFG_CC_BIT];
  wire next_ul    = underline_i & ~(cc_mode & serial_attr_i);
  wire next_shad  = shadow_i & (kind != osd_font_pkg::GLYPH_SPECIAL);
  wire lit        = pix_valid_i & next_on;

  // rgb is delayed two stages behind the lit decision so early blank has room
  logic       lit_d1;
  logic       lit_d2;
  logic [1:0] colour_d1;
  logic       ul_d1;
  logic       shad_d1;
  logic       fringe_d1;

  // first stage: lit and cell attributes wait here together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lit_d1    <= 1'b0;
      lit_d2    <= 1'b0;
      colour_d1 <= 2'b00;
      ul_d1     <= 1'b0;
      shad_d1   <= 1'b0;
      fringe_d1 <= 1'b0;
    end else begin
      lit_d1    <= lit;
      lit_d2    <= lit_d1;
      colour_d1 <= pix_valid_i ? next_colour : 2'b00;
      ul_d1     <= pix_valid_i & next_ul;
      shad_d1   <= pix_valid_i & next_shad;
      fringe_d1 <= pix_valid_i & next_fringe;
    end
  end

  // second stage: colour and attributes leave aligned with the lit flag,
  // otherwise the colour index would lead rgb on by one pixel
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pixel_colour_o <= 2'b00;
      pixel_on_o     <= 1'b0;
      underline_o    <= 1'b0;
      shadow_o       <= 1'b0;
      fringe_o       <= 1'b0;
    end else begin
      pixel_colour_o <= colour_d1;
      pixel_on_o     <= lit_d1;
      underline_o    <= ul_d1;
      shadow_o       <= shad_d1;
      fringe_o       <= fringe_d1;
    end
  end

  // blank windows: lit is rgb one cycle early, lit_d1 aligned, lit_d2 late;
  // registered so a config write changes the next pixel only, no glitch
  wire next_blank = (display_config[`CFG_EARLY_BIT] & lit) |
                    (display_config[`CFG_ALIGN_BIT] & lit_d1) |
                    (display_config[`CFG_LATE_BIT]  & lit_d2);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_blank_out        <= 1'b0;
      closed_caption_select <= 1'b0;
    end else begin
      fast_blank_out        <= next_blank;
      closed_caption_select <= cc_mode;
    end
  end

  // blank follows rgb exactly in the aligned-only setting
  property p_aligned_blank;
    @(posedge clk_i) disable iff (rst_i)
      (display_config[7:4] == 4'h2 && $stable(display_config)) ##1 $stable(display_config)
        |-> fast_blank_out == pixel_on_o;
  endproperty
  a_aligned_blank: assert property (p_aligned_blank) else $error("aligned blank differs from rgb");

  property p_off_blank;
    @(posedge clk_i) disable iff (rst_i)
      display_config[6:4] == 3'h0 |=> !fast_blank_out;
  endproperty
  a_off_blank: assert property (p_off_blank) else $error("blank active with code 000");

  property p_early_blank;
    @(posedge clk_i) disable iff (rst_i)
      (display_config[6:4] == 3'h1 ##1 display_config[6:4] == 3'h1 && fast_blank_out)
        |=> pixel_on_o;
  endproperty
  a_early_blank: assert property (p_early_blank) else $error("early blank not followed by rgb");

  property p_wide_blank;
    @(posedge clk_i) disable iff (rst_i)
      (display_config[6:4] == 3'h7 && lit) ##1 (display_config[6:4] == 3'h7) [*2]
        |-> ($past(fast_blank_out) && fast_blank_out) ##1 fast_blank_out;
  endproperty
  a_wide_blank: assert property (p_wide_blank) else $error("ored blank window missing");

  property p_cc_underline;
    @(posedge clk_i) disable iff (rst_i)
      (cc_mode && serial_attr_i) |-> ##2 !underline_o;
  endproperty
  a_cc_underline: assert property (p_cc_underline) else $error("underline shown on serial cell");

  property p_special_shadow;
    @(posedge clk_i) disable iff (rst_i)
      (kind == osd_font_pkg::GLYPH_SPECIAL) |-> ##2 !shadow_o;
  endproperty
  a_special_shadow: assert property (p_special_shadow) else $error("shadow on special glyph");

  property p_line15_dark;
    @(posedge clk_i) disable iff (rst_i)
      (char_line_i == 4'hf) |-> ##2 !pixel_on_o;
  endproperty
  a_line15_dark: assert property (p_line15_dark) else $error("unused line displayed");

  property p_prop_column;
    @(posedge clk_i) disable iff (rst_i)
      (kind == osd_font_pkg::GLYPH_PROP && !first_column_i) |-> !next_on;
  endproperty
  a_prop_column: assert property (p_prop_column) else $error("proportional glyph off first column");

  property p_cfg_reads;
    @(posedge clk_i) disable iff (rst_i)
      (req && !we_i && hit_cfg) |=> ack_o && dat_o == display_config && dat_o[3:0] == 4'h0;
  endproperty
  a_cfg_reads: assert property (p_cfg_reads) else $error("config read wrong");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than a cycle");

  // pixel path: blank windows, pipeline alignment and dark lines
  property p_late_blank;
    @(posedge clk_i) disable iff (rst_i)
      (display_config[6:4] == 3'h4 && lit) ##1 (display_config[6:4] == 3'h4) [*2] |=> fast_blank_out;
  endproperty
  a_late_blank: assert property (p_late_blank) else $error("late blank missing");

  property p_cc_copy;
    @(posedge clk_i) disable iff (rst_i)
      closed_caption_select == $past(display_config[`CFG_CC_BIT]);
  endproperty
  a_cc_copy: assert property (p_cc_copy) else $error("mode output differs from config bit");

  property p_on_pipe;
    @(posedge clk_i) disable iff (rst_i)
      pixel_on_o == $past(lit, 2);
  endproperty
  a_on_pipe: assert property (p_on_pipe) else $error("rgb on not two cycles after pixel");

  property p_colour_dark;
    @(posedge clk_i) disable iff (rst_i)
      !pixel_on_o |-> pixel_colour_o == 2'b00;
  endproperty
  a_colour_dark: assert property (p_colour_dark) else $error("colour shown on dark pixel");

  property p_prop_right_dark;
    @(posedge clk_i) disable iff (rst_i)
      (kind == osd_font_pkg::GLYPH_PROP && pix_col_i >= 4'h6) |-> !next_on;
  endproperty
  a_prop_right_dark: assert property (p_prop_right_dark) else $error("proportional low bits shown");

  property p_special_fringe_dark;
    @(posedge clk_i) disable iff (rst_i)
      (kind == osd_font_pkg::GLYPH_SPECIAL && (char_line_i == 4'h0 || char_line_i == 4'he)) |-> next_colour == 2'b00;
  endproperty
  a_special_fringe_dark: assert property (p_special_fringe_dark) else $error("special fringe shown");

  property p_wide_col_dark;
    @(posedge clk_i) disable iff (rst_i)
      (pix_col_i >= 4'hc) |-> !next_on;
  endproperty
  a_wide_col_dark: assert property (p_wide_col_dark) else $error("pixel beyond glyph width");

  property p_fringe_lines;
    @(posedge clk_i) disable iff (rst_i)
      !(char_line_i == 4'h0 || char_line_i == 4'he) |-> !next_fringe;
  endproperty
  a_fringe_lines: assert property (p_fringe_lines) else $error("fringe outside lines 0 and 14");

  property p_fringe_not_glyph;
    @(posedge clk_i) disable iff (rst_i)
      (char_line_i == 4'h0 || char_line_i == 4'he) |-> !next_on;
  endproperty
  a_fringe_not_glyph: assert property (p_fringe_not_glyph) else $error("fringe line drawn as glyph");

endmodule

//--- tb/video_sink.sv
// far-side video model: measures fast blank around lit rgb pixels
module video_sink (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  input  wire logic rgb_on_i,
  input  wire logic blank_i,
  output int        tot_o,
  output int        pre_o,
  output int        post_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  // blank cycles before, during and after the lit pixel; rgb seen marks the split
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      tot_o <= 0;
      pre_o <= 0;
      post_o <= 0;
      seen <= 1'b0;
    end else begin
      if (rgb_on_i) seen <= 1'b1;
      if (blank_i === 1'b1) tot_o <= tot_o + 1;
      if (blank_i === 1'b1 && !rgb_on_i && !seen) pre_o <= pre_o + 1;
      if (blank_i === 1'b1 && !rgb_on_i && seen) post_o <= post_o + 1;
    end
  end
endmodule

//--- tb/tb_osd_font_rom_blank_timing.sv
// self-checking bench for the glyph renderer and fast-blank timing
`include "osd_font_regs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module tb_osd_font_rom_blank_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, pv = 0, fc = 0, sa = 0, ul = 0, sh = 0, clr_s = 0;
  logic [15:0] adr = '0;
  logic [0:0] sel = 1'b1;
  logic [7:0] dat = '0, code = '0, q;
  logic [3:0] line = '0, col = '0;
  logic [7:0] rd;
  logic [1:0] clr_o, pc;
  logic ack, on, ulo, sho, fro, fb, ccs, pon, ulw, shw, fr;
  int num_errors = 0, cmp_count = 0, tot, pre, post;
  always #2 clk = ~clk;
  osd_font_rom_blank_timing DUT (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack), .pix_valid_i(pv), .char_code_i(code), .char_line_i(line),
    .pix_col_i(col), .first_column_i(fc), .serial_attr_i(sa), .underline_i(ul), .shadow_i(sh),
    .pixel_colour_o(clr_o), .pixel_on_o(pon), .underline_o(ulw), .shadow_o(shw), .fringe_o(fro),
    .fast_blank_out(fb), .closed_caption_select(ccs));
  video_sink sink (.clk_i(clk), .rst_i(rst), .clear_i(clr_s), .rgb_on_i(pon), .blank_i(fb), .tot_o(tot),
    .pre_o(pre), .post_o(post));
  task automatic summarize;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one classic cycle; request held until ack is seen at an edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    q = rd;
    cyc <= 0; stb <= 0;
    @(posedge clk);
    if (n >= 20) begin num_errors++; $display("ERROR %0t: no ack", $time); summarize(); end
  endtask
  // font word n sits at two byte addresses, low byte first
  task automatic fw(input int n, input logic [11:0] v);
    wb(1, 16'(`FONT_BASE_OFF + 2 * n), v[7:0]);
    wb(1, 16'(`FONT_BASE_OFF + 2 * n + 1), {4'h0, v[11:8]});
  endtask
  // one pixel slot, then idle so late blank can finish
  task automatic px(input logic [7:0] c, input logic [3:0] l, input logic [3:0] k, input logic f);
    pv <= 1; code <= c; line <= l; col <= k; fc <= f;
    @(posedge clk); pv <= 0;
    @(posedge clk); #1 on = pon; pc = clr_o; ulo = ulw; sho = shw; fr = fro;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs;
    wb(0, `DISPLAY_CONFIG_OFF, 8'h00); `CHK(q, 8'h00)
    `CHK(ccs, 1'b0)
    wb(1, `DISPLAY_CONFIG_OFF, 8'hb0); wb(0, `DISPLAY_CONFIG_OFF, 8'h00); `CHK(q, 8'hb0)
    `CHK(ccs, 1'b1)
    wb(0, 16'h87fe, 8'h00); `CHK(q, 8'h00)
    fw(37, 12'ha5c); wb(0, 16'hc04a, 8'h00); `CHK(q, 8'h5c)
    wb(0, 16'hc04b, 8'h00); `CHK(q, 8'h0a)
  endtask
  task automatic t_glyph;
    fw(2 * 16 + 1, 12'h800); fw(2 * 16 + 15, 12'hfff);
    px(2, 1, 0, 0); `CHK(on, 1'b1)
    px(2, 1, 1, 0); `CHK(on, 1'b0)
    px(2, 15, 0, 0); `CHK(on, 1'b0)
    fw(2 * 16, 12'h800); px(2, 0, 0, 0); `CHK(fr, 1'b1)
    `CHK(on, 1'b0)
    px(2, 1, 12, 0); `CHK(on, 1'b0)
  endtask
  task automatic t_blank;
    logic [2:0] codes[6] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b111, 3'b011};
    int et[6] = '{0, 1, 1, 1, 3, 2}, ep[6] = '{0, 1, 0, 0, 1, 1}, eq[6] = '{0, 0, 0, 1, 1, 0};
    for (int i = 0; i < 6; i++) begin
      wb(1, `DISPLAY_CONFIG_OFF, {1'b0, codes[i], 4'h0});
      clr_s <= 1; @(posedge clk); clr_s <= 0;
      px(2, 1, 0, 0);
      `CHK(tot, et[i])
      `CHK(pre, ep[i])
      `CHK(post, eq[i])
    end
  endtask
  task automatic t_cc;
    ul <= 1; sa <= 1;
    wb(1, `DISPLAY_CONFIG_OFF, 8'h80); px(2, 1, 0, 0); `CHK(ulo, 1'b0)
    wb(1, `DISPLAY_CONFIG_OFF, 8'h00); px(2, 1, 0, 0); `CHK(ulo, 1'b1)
    ul <= 0; sa <= 0;
  endtask
  task automatic t_special;
    fw(128 * 16 + 1, 12'hc00); fw(129 * 16 + 1, 12'ha00); sh <= 1;
    for (int k = 0; k < 3; k++) begin
      px(128, 1, 4'(k), 0); `CHK(pc, 2'(k == 0 ? 3 : k == 1 ? 1 : 2))
      `CHK(sho, 1'b0)
    end
    sh <= 0;
    fw(128 * 16, 12'hfff); px(128, 0, 0, 0); `CHK(pc, 2'b00)
    `CHK(fr, 1'b0)
  endtask
  task automatic t_prop;
    fw(160 * 16 + 1, 12'hfff);
    px(160, 1, 5, 1); `CHK(on, 1'b1)
    px(160, 1, 6, 1); `CHK(on, 1'b0)
    px(160, 1, 0, 0); `CHK(on, 1'b0)
  endtask
  // reset in mid-run: mode and outputs must return to plain display
  task automatic t_reset;
    wb(1, `DISPLAY_CONFIG_OFF, 8'h80);
    rst <= 1; repeat (3) @(posedge clk); rst <= 0;
    @(posedge clk); `CHK(ccs, 1'b0)
    `CHK(pon, 1'b0)
    wb(0, `DISPLAY_CONFIG_OFF, 8'h00); `CHK(q, 8'h00)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs(); t_glyph(); t_blank(); t_cc(); t_special(); t_prop(); t_reset();
    summarize();
  end
endmodule
